// ### core/sdma_top.sv
// Six-channel DMA engine with a Wishbone register slave and a memory master.
// Assumes memory/peripheral port answering on mem_ack_i, possibly after wait states.
// Notes on behaviour
// - channel moves bytes or words by size bit
// - word size after reset
// - byte mode address LSB picks byte lane
// - selected interrupt source triggers a transaction
// - trigger independent of programmed addresses
// - one-shot: one transaction per trigger
// - continuous: trigger runs counter-many transactions
// - repeated one-shot repeats until disabled
// - repeated continuous: series per trigger, repeating
// - reload pointers/counter; always in repeated modes
// - fixed or block addressing per pointer
// - block mode increments or decrements after transfer
// - peripheral offset added to base in indirect mode
// - collisions arbitrated by selected scheme
// - round-robin rotates upward from lower channel
// - fixed: lowest requester wins
// - fixed: just-served channel yields to next pending
// - two power-down groups, bits 4 and 5
// - five module and five channel registers
// - module enable clear aborts all channels
// - priority select one means round-robin
// - out-of-limit access terminated and flagged
// - mode encoding 00/01/10/11 as documented
`timescale 1ns/1ps
module sdma_top #(
  parameter int NCH = sdma_pkg::NUM_CH,
  parameter int NSRC = 128
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Trigger sources, one level per interrupt source
  input wire logic [NSRC-1:0] irq_src_i,
  // Peripheral indirect offset
  input wire logic [15:0] pia_off_i,
  // Memory master
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_adr_o,
  output logic [1:0] mem_be_o,
  output logic [15:0] mem_wdat_o,
  input wire logic [15:0] mem_rdat_i,
  input wire logic mem_ack_i,
  // Per-channel completion pulses
  output logic [NCH-1:0] done_o
);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [15:0] eng_r, hi_r, lo_r, buf_r, pmd_r;
  logic [15:0] ctl_r [NCH];
  logic [15:0] int_r [NCH];
  logic [15:0] src_r [NCH];
  logic [15:0] dst_r [NCH];
  logic [15:0] cnt_r [NCH];
  logic [15:0] src0_r [NCH]; // Reload copies
  logic [15:0] dst0_r [NCH];
  logic [15:0] cnt0_r [NCH];
  logic [NCH-1:0] pend_r; // Transaction pending
  logic [NCH-1:0] run_r; // Series in progress
  logic [NSRC-1:0] irq_q_r; // Previous trigger levels
  logic ack_r;
  sdma_pkg::sdma_state_t st_r;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Pointer step after a transfer
  function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m,
                                       input logic byte_m);
    logic [15:0] d;
    d = byte_m ? 16'h0001 : 16'h0002;
    case (m)
      sdma_pkg::AM_INC: step = a + d;
      sdma_pkg::AM_DEC: step = a - d;
      default: step = a;
    endcase
  endfunction

  // Effective address with peripheral offset
  function automatic logic [15:0] eff(input logic [15:0] a, input logic [1:0] m,
                                      input logic [15:0] off);
    eff = (m == sdma_pkg::AM_PIA) ? a + off : a;
  endfunction

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire logic bus_req = cyc_i & stb_i & ~ack_r;
  wire logic wr_lo = bus_req & we_i & sel_i[0];
  wire logic wr_hi = bus_req & we_i & sel_i[1];
  wire logic [7:0] ch_off = adr_i - sdma_pkg::OFF_CH_BASE;
  wire logic in_ch = adr_i >= sdma_pkg::OFF_CH_BASE;
  wire logic [2:0] ch_sel = ch_off[7:5];
  wire logic [2:0] ch_reg = ch_off[4:2];
  wire logic ch_ok = in_ch && (int'(ch_sel) < NCH) && (ch_reg <= sdma_pkg::CH_CNT_IDX);
  wire logic en = eng_r[sdma_pkg::ENG_EN_BIT];
  wire logic [15:0] wmask = {{8{wr_hi}}, {8{wr_lo}}};

  // Power group gating per channel
  function automatic logic ch_pwr(input int c, input logic [15:0] p);
    ch_pwr = (c < 4) ? ~p[sdma_pkg::PMD_GRP_LO_BIT] : ~p[sdma_pkg::PMD_GRP_HI_BIT];
  endfunction

  // ----------------------------------------------------------------------
  // Triggers and arbitration
  // ----------------------------------------------------------------------
  logic [NCH-1:0] trig, live, gnt;
  logic any_req;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      logic [6:0] s;
      s = int_r[c][sdma_pkg::INT_TRIG_LSB +: 7];
      // Rising edge of the chosen source; source number 0 never triggers
      trig[c] = (s != 7'h00) && (int'(s) < NSRC) && irq_src_i[s] && !irq_q_r[s];
      live[c] = en && ctl_r[c][sdma_pkg::CH_EN_BIT] && ch_pwr(c, pmd_r);
    end
  end

  logic take;
  sdma_arb #(.N(NCH)) u_arb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rr_i(eng_r[sdma_pkg::ENG_PRS_BIT]),
    .take_i(take),
    .req_i(pend_r & live),
    .gnt_o(gnt),
    .any_o(any_req)
  );

  // Granted channel index
  logic [2:0] gi;
  always_comb begin
    gi = 3'h0;
    for (int c = 0; c < NCH; c++) begin
      if (gnt[c]) begin
        gi = 3'(c);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transfer engine state
  // ----------------------------------------------------------------------
  logic [2:0] cur_r;
  wire logic [15:0] cc = ctl_r[cur_r];
  wire logic byte_m = cc[sdma_pkg::CH_SIZE_BIT];
  wire logic [1:0] trm = cc[sdma_pkg::CH_TRM_LSB +: 2];
  wire logic [1:0] sam = cc[sdma_pkg::CH_SAM_LSB +: 2];
  wire logic [1:0] dam = cc[sdma_pkg::CH_DAM_LSB +: 2];
  wire logic [15:0] s_ea = eff(src_r[cur_r], sam, pia_off_i);
  wire logic [15:0] d_ea = eff(dst_r[cur_r], dam, pia_off_i);
  wire logic [15:0] ea = (st_r == sdma_pkg::ST_WRITE) ? d_ea : s_ea;
  // Limit check; lower limit only above SFR space, upper limit at every address
  wire logic hi_viol = (ea > hi_r);
  wire logic lo_viol = (ea > sdma_pkg::SFR_TOP) && (ea < lo_r);
  wire logic rep = trm[0]; // Repeated modes
  wire logic cont = trm[1]; // Continuous modes
  wire logic [15:0] cnt_dec = cnt_r[cur_r] - 16'h0001;
  wire logic last = (cnt_dec == 16'h0000);
  wire logic busy = (st_r != sdma_pkg::ST_IDLE);
  assign take = (st_r == sdma_pkg::ST_IDLE) && any_req;

  // Byte lane from address LSB
  wire logic lane = ea[0];
  wire logic [15:0] rd_data = byte_m ? (lane ? {8'h00, mem_rdat_i[15:8]}
                                              : {8'h00, mem_rdat_i[7:0]}) : mem_rdat_i;

  assign mem_req_o = busy && !(hi_viol || lo_viol);
  assign mem_we_o = (st_r == sdma_pkg::ST_WRITE);
  assign mem_adr_o = {ea[15:1], 1'b0};
  assign mem_be_o = byte_m ? (lane ? 2'b10 : 2'b01) : 2'b11;
  assign mem_wdat_o = byte_m ? {buf_r[7:0], buf_r[7:0]} : buf_r;

  // ----------------------------------------------------------------------
  // Engine sequencer and channel registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= sdma_pkg::ST_IDLE;
      cur_r <= 3'h0;
      buf_r <= 16'h0000;
      pend_r <= '0;
      run_r <= '0;
      irq_q_r <= '0;
      done_o <= '0;
      eng_r <= 16'h0000;
      hi_r <= sdma_pkg::LIMIT_HI_RST;
      lo_r <= sdma_pkg::LIMIT_LO_RST;
      pmd_r <= 16'h0000;
      for (int c = 0; c < NCH; c++) begin
        ctl_r[c] <= sdma_pkg::CH_CTRL_RST;
        int_r[c] <= 16'h0000;
        src_r[c] <= 16'h0000;
        dst_r[c] <= 16'h0000;
        cnt_r[c] <= 16'h0000;
        src0_r[c] <= 16'h0000;
        dst0_r[c] <= 16'h0000;
        cnt0_r[c] <= 16'h0000;
      end
    end else begin
      irq_q_r <= irq_src_i;
      done_o <= '0;
      // Software register writes
      if (wr_lo || wr_hi) begin
        case (adr_i)
          sdma_pkg::OFF_ENGINE_CTRL: eng_r <= (eng_r & ~wmask) | (dat_i[15:0] & wmask &
                                               sdma_pkg::ENG_CTRL_MASK);
          sdma_pkg::OFF_UPPER_LIMIT: hi_r <= (hi_r & ~wmask) | (dat_i[15:0] & wmask);
          sdma_pkg::OFF_LOWER_LIMIT: lo_r <= (lo_r & ~wmask) | (dat_i[15:0] & wmask);
          sdma_pkg::OFF_DATA_BUF: buf_r <= (buf_r & ~wmask) | (dat_i[15:0] & wmask);
          sdma_pkg::OFF_MODULE_DIS: pmd_r <= (pmd_r & ~wmask) | (dat_i[15:0] & wmask);
          default: begin
            if (ch_ok) begin
              case (ch_reg)
                sdma_pkg::CH_CTRL_IDX: ctl_r[ch_sel] <= (ctl_r[ch_sel] & ~wmask) |
                                        (dat_i[15:0] & wmask & sdma_pkg::CH_CTRL_MASK);
                sdma_pkg::CH_INT_IDX: int_r[ch_sel] <= (int_r[ch_sel] & ~wmask) |
                                       (dat_i[15:0] & wmask & 16'h7ff9);
                sdma_pkg::CH_SRC_IDX: begin
                  src_r[ch_sel] <= dat_i[15:0];
                  src0_r[ch_sel] <= dat_i[15:0];
                end
                sdma_pkg::CH_DST_IDX: begin
                  dst_r[ch_sel] <= dat_i[15:0];
                  dst0_r[ch_sel] <= dat_i[15:0];
                end
                sdma_pkg::CH_CNT_IDX: begin
                  cnt_r[ch_sel] <= dat_i[15:0];
                  cnt0_r[ch_sel] <= dat_i[15:0];
                end
                default: ;
              endcase
            end
          end
        endcase
      end
      // Trigger capture; overrun if still pending or running
      for (int c = 0; c < NCH; c++) begin
        if (!live[c]) begin
          pend_r[c] <= 1'b0;
          run_r[c] <= 1'b0;
        end else if (trig[c] || ctl_r[c][sdma_pkg::CH_REQ_BIT]) begin
          if (pend_r[c] || run_r[c]) begin
            int_r[c][sdma_pkg::INT_OVR_BIT] <= 1'b1;
          end
          pend_r[c] <= 1'b1;
          run_r[c] <= ctl_r[c][sdma_pkg::CH_TRM_LSB + 1];
        end
      end
      // Sequencer
      case (st_r)
        sdma_pkg::ST_IDLE: begin
          if (!en) begin
            st_r <= sdma_pkg::ST_IDLE;
          end else if (any_req) begin
            cur_r <= gi;
            pend_r[gi] <= 1'b0;
            st_r <= sdma_pkg::ST_READ;
          end
        end
        sdma_pkg::ST_READ: begin
          if (!en || !live[cur_r]) begin
            st_r <= sdma_pkg::ST_IDLE;
          end else if (hi_viol || lo_viol) begin
            int_r[cur_r][sdma_pkg::INT_HIGH_BIT] <= hi_viol;
            int_r[cur_r][sdma_pkg::INT_LOW_BIT] <= lo_viol;
            run_r[cur_r] <= 1'b0;
            st_r <= sdma_pkg::ST_IDLE;
          end else if (mem_ack_i) begin
            buf_r <= rd_data;
            st_r <= sdma_pkg::ST_WRITE;
          end
        end
        sdma_pkg::ST_WRITE: begin
          if (!en || !live[cur_r]) begin
            st_r <= sdma_pkg::ST_IDLE;
          end else if (hi_viol || lo_viol) begin
            int_r[cur_r][sdma_pkg::INT_HIGH_BIT] <= hi_viol;
            int_r[cur_r][sdma_pkg::INT_LOW_BIT] <= lo_viol;
            run_r[cur_r] <= 1'b0;
            st_r <= sdma_pkg::ST_IDLE;
          end else if (mem_ack_i) begin
            st_r <= sdma_pkg::ST_IDLE;
            src_r[cur_r] <= step(src_r[cur_r], sam, byte_m);
            dst_r[cur_r] <= step(dst_r[cur_r], dam, byte_m);
            cnt_r[cur_r] <= cnt_dec;
            if (cnt_dec == (cnt0_r[cur_r] >> 1) && int_r[cur_r][sdma_pkg::INT_HALFEN_BIT]) begin
              int_r[cur_r][sdma_pkg::INT_HALF_BIT] <= 1'b1;
            end
            if (cont && !last && run_r[cur_r]) begin
              pend_r[cur_r] <= 1'b1;
            end
            if (last) begin
              run_r[cur_r] <= 1'b0;
              done_o[cur_r] <= 1'b1;
              int_r[cur_r][sdma_pkg::INT_DONE_BIT] <= 1'b1;
              ctl_r[cur_r][sdma_pkg::CH_REQ_BIT] <= 1'b0;
              if (rep || cc[sdma_pkg::CH_RELOAD_BIT]) begin
                src_r[cur_r] <= src0_r[cur_r];
                dst_r[cur_r] <= dst0_r[cur_r];
                cnt_r[cur_r] <= cnt0_r[cur_r];
              end
              if (!rep) begin
                ctl_r[cur_r][sdma_pkg::CH_EN_BIT] <= 1'b0;
              end
            end
          end
        end
        default: st_r <= sdma_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read mux and ack
  // ----------------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (adr_i)
      sdma_pkg::OFF_ENGINE_CTRL: rd_mux = eng_r;
      sdma_pkg::OFF_UPPER_LIMIT: rd_mux = hi_r;
      sdma_pkg::OFF_LOWER_LIMIT: rd_mux = lo_r;
      sdma_pkg::OFF_DATA_BUF: rd_mux = buf_r;
      sdma_pkg::OFF_MODULE_DIS: rd_mux = pmd_r;
      default: begin
        if (ch_ok) begin
          case (ch_reg)
            sdma_pkg::CH_CTRL_IDX: rd_mux = ctl_r[ch_sel];
            sdma_pkg::CH_INT_IDX: rd_mux = int_r[ch_sel];
            sdma_pkg::CH_SRC_IDX: rd_mux = src_r[ch_sel];
            sdma_pkg::CH_DST_IDX: rd_mux = dst_r[ch_sel];
            default: rd_mux = cnt_r[ch_sel];
          endcase
        end
      end
    endcase
  end

  // Ack one cycle after request, data registered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      dat_o <= {16'h0000, rd_mux};
    end
  end
  assign ack_o = ack_r;

endmodule

// ### core/sdma_pkg.sv
// Package for the six-channel DMA engine: register map, field positions,
// reset values and encodings.
// Assumes a classic Wishbone slave with 32-bit data, 16-bit registers in low bits.
package sdma_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------------
  // Module-level register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_ENGINE_CTRL = 8'h00;
  localparam logic [7:0] OFF_UPPER_LIMIT = 8'h04;
  localparam logic [7:0] OFF_LOWER_LIMIT = 8'h08;
  localparam logic [7:0] OFF_DATA_BUF = 8'h0c;
  localparam logic [7:0] OFF_MODULE_DIS = 8'h10;
  // Channel block base and stride; eight words per channel, five used
  localparam logic [7:0] OFF_CH_BASE = 8'h20;
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [2:0] CH_CTRL_IDX = 3'h0;
  localparam logic [2:0] CH_INT_IDX = 3'h1;
  localparam logic [2:0] CH_SRC_IDX = 3'h2;
  localparam logic [2:0] CH_DST_IDX = 3'h3;
  localparam logic [2:0] CH_CNT_IDX = 3'h4;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ENG_EN_BIT = 15;
  localparam int ENG_PRS_BIT = 0;
  localparam int PMD_GRP_LO_BIT = 4;
  localparam int PMD_GRP_HI_BIT = 5;
  localparam int CH_EN_BIT = 0;
  localparam int CH_SIZE_BIT = 1;
  localparam int CH_TRM_LSB = 2;
  localparam int CH_DAM_LSB = 4;
  localparam int CH_SAM_LSB = 6;
  localparam int CH_REQ_BIT = 8;
  localparam int CH_RELOAD_BIT = 9;
  localparam int INT_TRIG_LSB = 8;
  localparam int INT_HIGH_BIT = 7;
  localparam int INT_LOW_BIT = 6;
  localparam int INT_DONE_BIT = 5;
  localparam int INT_HALF_BIT = 4;
  localparam int INT_OVR_BIT = 3;
  localparam int INT_HALFEN_BIT = 0;

  // ----------------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] CH_CTRL_MASK = 16'h03ff;
  localparam logic [15:0] CH_CTRL_RST = 16'h0000;
  localparam logic [15:0] ENG_CTRL_MASK = 16'h8001;
  localparam logic [15:0] LIMIT_HI_RST = 16'hffff;
  localparam logic [15:0] LIMIT_LO_RST = 16'h0800;
  localparam logic [15:0] SFR_TOP = 16'h07ff;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] TRM_ONESHOT = 2'h0;
  localparam logic [1:0] TRM_REP_ONESHOT = 2'h1;
  localparam logic [1:0] TRM_CONT = 2'h2;
  localparam logic [1:0] TRM_REP_CONT = 2'h3;
  localparam logic [1:0] AM_FIXED = 2'h0;
  localparam logic [1:0] AM_INC = 2'h1;
  localparam logic [1:0] AM_DEC = 2'h2;
  localparam logic [1:0] AM_PIA = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} sdma_state_t;

endpackage

// ### core/sdma_arb.sv
// Channel arbiter for the DMA engine: fixed or round-robin grant.
// Assumes requests are level and held until granted.
`timescale 1ns/1ps
module sdma_arb #(
  parameter int N = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic rr_i,
  input wire logic take_i,
  // Requests and grant
  input wire logic [N-1:0] req_i,
  output logic [N-1:0] gnt_o,
  output logic any_o
);

  // ----------------------------------------------------------------------
  // Priority pick starting from a pointer
  // ----------------------------------------------------------------------
  function automatic logic [N-1:0] pick(input logic [N-1:0] r, input int start);
    logic [N-1:0] g;
    int k;
    g = '0;
    for (int i = N - 1; i >= 0; i--) begin
      k = (start + i) % N;
      if (r[k]) begin
        g = '0;
        g[k] = 1'b1;
      end
    end
    return g;
  endfunction

  // Last served channel, one-hot
  logic [N-1:0] last_r;
  logic [2:0] ptr_r;
  // Lowest requester, and lowest excluding last served
  wire logic [N-1:0] low_pick = pick(req_i, 0);
  wire logic [N-1:0] req_excl = req_i & ~last_r;
  wire logic [N-1:0] fix_pick = (req_excl != '0) ? pick(req_excl, 0) : low_pick;
  wire logic [N-1:0] rr_pick = pick(req_i, int'(ptr_r));

  assign gnt_o = rr_i ? rr_pick : fix_pick;
  assign any_o = req_i != '0;

  // ----------------------------------------------------------------------
  // History update on each grant taken
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_r <= '0;
      ptr_r <= 3'h0;
    end else if (take_i) begin
      last_r <= gnt_o;
      for (int i = 0; i < N; i++) begin
        if (gnt_o[i]) begin
          ptr_r <= (i == N - 1) ? 3'h0 : 3'(i + 1);
        end
      end
    end
  end

endmodule

// ### tb/sdma_checker.sv
// ----------------------------------------------------------------------
// Checker for the DMA engine: bus answer, memory port, completion
// ----------------------------------------------------------------------
// Assumes it is bound to sdma_top and sees only that module's ports.
`timescale 1ns/1ps
module sdma_checker #(
  parameter int NCH = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Memory port
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [15:0] mem_adr_o,
  input wire logic [1:0] mem_be_o,
  input wire logic mem_ack_i,
  // Completion pulses
  input wire logic [NCH-1:0] done_o
);
  // Single domain, reset disables all checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("register access not answered in one cycle");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_req: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  a_unmapped_zero: assert property (cyc_i && stb_i && !we_i && !ack_o && adr_i == 8'h14
    |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_mem_held: assert property (mem_req_o && !mem_ack_i
    |=> mem_req_o && $stable(mem_adr_o) && $stable(mem_we_o))
    else $error("memory request changed before answer");
  a_word_aligned: assert property (mem_req_o |-> !mem_adr_o[0])
    else $error("memory address not word aligned");
  a_lane_valid: assert property (mem_req_o |-> mem_be_o inside {2'b01, 2'b10, 2'b11})
    else $error("no byte lane selected");
  a_done_pulse: assert property (|done_o |=> done_o == '0)
    else $error("completion pulse too long");
  a_done_onehot: assert property ($onehot0(done_o))
    else $error("two channels completed at once");
endmodule

bind sdma_top sdma_checker #(.NCH(NCH)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
  .ack_o(ack_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
  .mem_adr_o(mem_adr_o), .mem_be_o(mem_be_o), .mem_ack_i(mem_ack_i),
  .done_o(done_o));

// ### tb/sdma_mem_model.sv
// ----------------------------------------------------------------------
// Data RAM model on the engine's memory port
// ----------------------------------------------------------------------
// Assumes requests are held until acknowledged; wait states set by lat_i.
`timescale 1ns/1ps
module sdma_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wait states before each answer
  input wire logic [1:0] lat_i,
  // Memory port from the engine
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [1:0] be_i,
  input wire logic [15:0] wdat_i,
  output logic [15:0] rdat_o,
  output logic ack_o,
  // Writes taken so far
  output logic [15:0] wr_cnt_o
);
  logic [15:0] mem [0:32767]; // Word storage
  logic [1:0] wait_r; // Wait states spent

  // Each word preset to its own pattern
  initial for (int i = 0; i < 32768; i++) mem[i] = 16'(i) ^ 16'ha5c3;

  // Answer after the wait states; idle data toggles every cycle
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_r <= 2'h0;
      rdat_o <= 16'h0;
      wr_cnt_o <= 16'h0;
    end else if (req_i && !ack_o && wait_r == lat_i) begin
      ack_o <= 1'b1;
      wait_r <= 2'h0;
      rdat_o <= mem[adr_i[15:1]];
      if (we_i) begin
        if (be_i[0]) mem[adr_i[15:1]][7:0] <= wdat_i[7:0];
        if (be_i[1]) mem[adr_i[15:1]][15:8] <= wdat_i[15:8];
        wr_cnt_o <= wr_cnt_o + 16'h1;
      end
    end else begin
      ack_o <= 1'b0;
      wait_r <= (req_i && !ack_o) ? wait_r + 2'h1 : 2'h0;
      rdat_o <= ~rdat_o;
    end
  end
endmodule

// ### tb/testbench.sv
// ----------------------------------------------------------------------
// Testbench for the six-channel DMA engine
// ----------------------------------------------------------------------
// Assumes the register map of sdma_pkg and the memory model on the far side.
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h0;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic ack_o, mem_req_o, mem_we_o, mem_ack_i;
  logic [127:0] irq_src_i = '0;
  logic [15:0] pia_off_i = 16'h0, mem_adr_o, mem_wdat_o, mem_rdat_i, wr_cnt, w0;
  logic [1:0] mem_be_o, lat = 2'h0;
  logic [5:0] done_o;
  int error_cnt = 0, samples_checked = 0;

  always #5 clk_i = ~clk_i;

  sdma_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .irq_src_i(irq_src_i), .pia_off_i(pia_off_i),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_adr_o(mem_adr_o),
    .mem_be_o(mem_be_o), .mem_wdat_o(mem_wdat_o), .mem_rdat_i(mem_rdat_i),
    .mem_ack_i(mem_ack_i), .done_o(done_o));
  sdma_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .req_i(mem_req_o),
    .we_i(mem_we_o), .adr_i(mem_adr_o), .be_i(mem_be_o), .wdat_i(mem_wdat_o),
    .rdat_o(mem_rdat_i), .ack_o(mem_ack_i), .wr_cnt_o(wr_cnt));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] pat(input logic [15:0] w);
    return w ^ 16'ha5c3;
  endfunction
  function automatic logic [7:0] cha(input int ch, input logic [2:0] idx);
    return sdma_pkg::OFF_CH_BASE + 8'(ch) * sdma_pkg::CH_STRIDE + {3'h0, idx, 2'h0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 16'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task automatic trig(input int s);
    @(posedge clk_i);
    irq_src_i[s] <= 1'b1;
    @(posedge clk_i);
    irq_src_i[s] <= 1'b0;
  endtask
  task automatic wait_done(input int ch);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done_o[ch] !== 1'b1 && n < 300);
    chk("done", 1, done_o[ch]);
  endtask
  // Disable, program, enable, then select the trigger
  task automatic setup(input int ch, input logic [15:0] s, d, c, ctl, input int src);
    wb(1, cha(ch, sdma_pkg::CH_CTRL_IDX), 16'h0);
    wb(1, cha(ch, sdma_pkg::CH_SRC_IDX), s);
    wb(1, cha(ch, sdma_pkg::CH_DST_IDX), d);
    wb(1, cha(ch, sdma_pkg::CH_CNT_IDX), c);
    wb(1, cha(ch, sdma_pkg::CH_CTRL_IDX), ctl);
    wb(1, cha(ch, sdma_pkg::CH_INT_IDX), {1'b0, 7'(src), 8'h0});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    wb(0, sdma_pkg::OFF_UPPER_LIMIT, 16'h0);
    chk("upper", 32'hffff, rd);
    wb(0, sdma_pkg::OFF_LOWER_LIMIT, 16'h0);
    chk("lower", 32'h0800, rd);
    wb(0, sdma_pkg::OFF_ENGINE_CTRL, 16'h0);
    chk("engine", 32'h0, rd);
    wb(0, cha(0, sdma_pkg::CH_CTRL_IDX), 16'h0);
    chk("size", 32'h0, rd);
    wb(1, 8'h14, 16'hbeef);
    wb(0, 8'h14, 16'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_cont;
    lat <= 2'h2;
    wb(1, sdma_pkg::OFF_ENGINE_CTRL, 16'h8000);
    setup(0, 16'h0900, 16'h0a00, 16'h2, 16'h0059, 5);
    trig(5);
    wait_done(0);
    chk("blk0", pat(16'h0480), mem_u.mem[16'h0500]);
    chk("blk1", pat(16'h0481), mem_u.mem[16'h0501]);
    wb(0, cha(0, sdma_pkg::CH_CNT_IDX), 16'h0);
    chk("count", 32'h0, rd);
  endtask
  task automatic t_oneshot;
    lat <= 2'h0;
    pia_off_i <= 16'h1;
    setup(1, 16'h0900, 16'h0c00, 16'h2, 16'h00c3, 6);
    w0 = wr_cnt;
    trig(6);
    repeat (30) @(posedge clk_i);
    chk("one", w0 + 16'h1, wr_cnt);
    chk("byte", {8'(pat(16'h0600) >> 8), 8'(pat(16'h0480) >> 8)}, mem_u.mem[16'h0600]);
    trig(6);
    wait_done(1);
  endtask
  task automatic t_limit;
    wb(1, sdma_pkg::OFF_LOWER_LIMIT, 16'h1000);
    setup(2, 16'h2000, 16'h0900, 16'h1, 16'h0001, 7);
    w0 = wr_cnt;
    trig(7);
    repeat (30) @(posedge clk_i);
    chk("blocked", w0, wr_cnt);
    wb(0, cha(2, sdma_pkg::CH_INT_IDX), 16'h0);
    chk("lowflag", 1, rd[sdma_pkg::INT_LOW_BIT]);
    wb(1, sdma_pkg::OFF_LOWER_LIMIT, 16'h0800);
  endtask
  task automatic t_fixed;
    int n;
    setup(4, 16'h0900, 16'h0e02, 16'h1, 16'h0001, 9);
    setup(3, 16'h0900, 16'h0e00, 16'h1, 16'h0001, 9);
    trig(9);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done_o === 6'h0 && n < 300);
    chk("first", 6'h08, done_o);
    wait_done(4);
  endtask

  task automatic end_sim;
    $display("error_cnt=%0d samples_checked=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    end_sim;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_cont;
    t_oneshot;
    t_limit;
    t_fixed;
    end_sim;
  end
endmodule
